// ---- design/vdfw_write_port.v ----
// Display FIFO write window: decodes DMA writes into luma, blue- and
// red-difference FIFOs and raises the DMA request events that pace them.
// Assumes the DMA agent holds a request until the window acknowledges it.
`timescale 1ns/1ps
`include "vdfw_map.vh"

// Overview of operation
// - In component modes, three DMA channels each fill their own FIFO through their own destination.
// - Each FIFO has its own request event, and its transfers start only on that event.
// - In raw mode one DMA channel writes through the luma destination into the luma FIFO only.
// - In raw mode only the luma request event paces transfers; chroma events stay quiet.
// - The blue-difference destination feeds its FIFO in component modes and does nothing in raw mode.
// - The red-difference destination feeds its FIFO in component modes and does nothing in raw mode.
// - The destinations are write-only targets.
// - A read of any destination returns a fixed value and changes no FIFO state.
// - Destinations decode as window base plus 20h for luma, 28h for blue, 30h for red.
// - Luma destinations A and B both sit at offset 20h and reach the same FIFO.
module vdfw_write_port (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,

    // Display control
    input  wire [1:0]  disp_mode,
    input  wire        disp_enable,
    input  wire        disp_flush,

    // DMA write window
    input  wire        win_sel,
    input  wire        win_we,
    input  wire [7:0]  win_addr,
    input  wire [31:0] win_wdata,
    output wire        win_ack,
    output wire [31:0] win_rdata,

    // DMA request events
    output wire        luma_dma_request,
    output wire        blue_diff_dma_request,
    output wire        red_diff_dma_request,

    // Luma FIFO drain
    output wire        luma_out_valid,
    input  wire        luma_out_ready,
    output wire [31:0] luma_out_data,

    // Blue-difference FIFO drain
    output wire        blue_out_valid,
    input  wire        blue_out_ready,
    output wire [31:0] blue_out_data,

    // Red-difference FIFO drain
    output wire        red_out_valid,
    input  wire        red_out_ready,
    output wire [31:0] red_out_data,

    // Status
    output wire [3:0]  luma_level,
    output wire [3:0]  blue_level,
    output wire [3:0]  red_level,
    output wire        discard_seen
);

    // Mode decode.
    wire        raw_mode;
    wire [2:0]  ch_active;

    // Address decode.
    wire        hit_luma;
    wire        hit_blue;
    wire        hit_red;
    wire [2:0]  hit;
    wire        wr_req;
    wire        rd_req;
    wire        wr_mapped;
    wire        wr_discard;
    wire        wr_ok;

    // Per-channel FIFO wiring.
    wire [2:0]  fifo_in_valid;
    wire [2:0]  fifo_in_ready;
    wire [2:0]  fifo_out_valid;
    wire [2:0]  fifo_out_ready;
    wire [95:0] fifo_out_data;
    wire [11:0] fifo_level;
    wire [2:0]  ch_req;

    // Read answer and sticky status.
    reg         rd_ack_reg;
    reg         rd_ack_next;
    reg  [31:0] rdata_reg;
    reg  [31:0] rdata_next;
    reg         discard_reg;
    reg         discard_next;

    assign raw_mode = (disp_mode == `VDFW_MODE_RAW);

    // Chroma channels stand idle in raw mode.
    assign ch_active[0] = disp_enable;
    assign ch_active[1] = disp_enable & ~raw_mode;
    assign ch_active[2] = disp_enable & ~raw_mode;

    // Luma A and B share one offset and therefore one decode term.
    assign hit_luma = (win_addr == `VDFW_LUMA_DEST_A) |
                      (win_addr == `VDFW_LUMA_DEST_B);
    assign hit_blue = (win_addr == `VDFW_BLUE_DEST);
    assign hit_red  = (win_addr == `VDFW_RED_DEST);
    assign hit      = {hit_red, hit_blue, hit_luma};

    assign wr_req = win_sel & win_we;
    assign rd_req = win_sel & ~win_we;

    // A write lands only in a channel that the mode leaves active.
    assign wr_mapped  = |(hit & ch_active);
    assign wr_discard = wr_req & ~wr_mapped;

    // Writes to a full FIFO stall the DMA agent until room appears.
    assign wr_ok = wr_discard | (|(hit & ch_active & fifo_in_ready));

    assign fifo_in_valid = {3{wr_req}} & hit & ch_active;

    // Writes answer in the cycle taken; reads answer one cycle later.
    // The read answer only qualifies a read still on the window, so a
    // write that follows a read at once waits for room in its own FIFO.
    assign win_ack   = (wr_req & wr_ok) | (rd_req & rd_ack_reg);
    assign win_rdata = rdata_reg;

    // Request states of each channel, one-hot.
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_WAIT  = 3'b010;
    localparam [2:0] ST_BURST = 3'b100;

    genvar ch;
    generate
        for (ch = 0; ch < `VDFW_NUM_CH; ch = ch + 1)
        begin : g_ch
            reg [2:0] state_reg;
            reg [2:0] state_next;
            reg [2:0] burst_reg;
            reg [2:0] burst_next;
            reg       pulse_reg;
            reg       pulse_next;
            wire      take;
            wire      room;
            wire      halt;

            vdfw_fifo #(
                .WIDTH (`VDFW_DATA_W),
                .DEPTH (`VDFW_FIFO_DEPTH),
                .AW    (3),
                .LW    (`VDFW_LEVEL_W)
            ) u_fifo (
                .clk       (clk),
                .rst_n     (rst_n),
                .flush     (disp_flush),
                .in_valid  (fifo_in_valid[ch]),
                .in_ready  (fifo_in_ready[ch]),
                .in_data   (win_wdata),
                .out_valid (fifo_out_valid[ch]),
                .out_ready (fifo_out_ready[ch]),
                .out_data  (fifo_out_data[ch*32 +: 32]),
                .level     (fifo_level[ch*4 +: 4])
            );

            assign take = fifo_in_valid[ch] & fifo_in_ready[ch];
            assign halt = ~ch_active[ch] | disp_flush;

            // A request is raised only while a whole burst still fits.
            assign room = (fifo_level[ch*4 +: 4] <= `VDFW_REQ_LEVEL);

            always @*
            begin
                state_next = state_reg;
                burst_next = burst_reg;
                pulse_next = 1'b0;
                case (state_reg)
                    ST_IDLE:
                    begin
                        // Channel off or flushed: nothing may be requested.
                        burst_next = 3'h0;
                        if (!halt)
                        begin
                            if (room)
                            begin
                                state_next = ST_BURST;
                                pulse_next = 1'b1;
                            end
                            else
                            begin
                                state_next = ST_WAIT;
                            end
                        end
                    end
                    ST_WAIT:
                    begin
                        // Active but too full for another burst.
                        burst_next = 3'h0;
                        if (halt)
                        begin
                            state_next = ST_IDLE;
                        end
                        else if (room)
                        begin
                            state_next = ST_BURST;
                            pulse_next = 1'b1;
                        end
                    end
                    ST_BURST:
                    begin
                        // Counts the words of the burst that was asked for.
                        if (halt)
                        begin
                            state_next = ST_IDLE;
                            burst_next = 3'h0;
                        end
                        else if (take)
                        begin
                            if (burst_reg == `VDFW_BURST_LAST)
                            begin
                                state_next = ST_WAIT;
                                burst_next = 3'h0;
                            end
                            else
                            begin
                                burst_next = burst_reg + 3'h1;
                            end
                        end
                    end
                    default:
                    begin
                        state_next = ST_IDLE;
                        burst_next = 3'h0;
                    end
                endcase
            end

            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    state_reg <= ST_IDLE;
                    burst_reg <= 3'h0;
                end
                else
                begin
                    state_reg <= state_next;
                    burst_reg <= burst_next;
                end
            end

            // The event leaves from its own flop so it is one clean cycle.
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pulse_reg <= 1'b0;
                end
                else
                begin
                    pulse_reg <= pulse_next;
                end
            end

            // Chroma events never fire while raw mode holds them idle.
            assign ch_req[ch] = pulse_reg & ch_active[ch];
        end
    endgenerate

    assign luma_dma_request      = ch_req[0];
    assign blue_diff_dma_request = ch_req[1];
    assign red_diff_dma_request  = ch_req[2];

    // Each FIFO drains straight to its own port group.
    assign fifo_out_ready = {red_out_ready, blue_out_ready, luma_out_ready};

    assign luma_out_valid = fifo_out_valid[0];
    assign blue_out_valid = fifo_out_valid[1];
    assign red_out_valid  = fifo_out_valid[2];
    assign luma_out_data  = fifo_out_data[31:0];
    assign blue_out_data  = fifo_out_data[63:32];
    assign red_out_data   = fifo_out_data[95:64];

    // Fill levels go out as they stand in each FIFO's counter.
    assign luma_level = fifo_level[3:0];
    assign blue_level = fifo_level[7:4];
    assign red_level  = fifo_level[11:8];

    // Reads touch nothing but the answer flops; FIFO state is untouched.
    always @*
    begin
        rd_ack_next = 1'b0;
        rdata_next  = rdata_reg;
        if (rd_req && !rd_ack_reg)
        begin
            rd_ack_next = 1'b1;
            rdata_next  = `VDFW_READ_VALUE;
        end
    end

    // Sticky flag for writes dropped by mode, display enable or address; flush clears it.
    always @*
    begin
        discard_next = discard_reg;
        if (disp_flush)
        begin
            discard_next = 1'b0;
        end
        if (wr_discard)
        begin
            discard_next = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ack_reg <= 1'b0;
        end
        else
        begin
            rd_ack_reg <= rd_ack_next;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= `VDFW_READ_VALUE;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            discard_reg <= 1'b0;
        end
        else
        begin
            discard_reg <= discard_next;
        end
    end

    assign discard_seen = discard_reg;

endmodule // vdfw_write_port

// ---- design/vdfw_map.vh ----
// Constants for the display FIFO write window: offsets, modes and pacing.
// Assumes window offsets are byte addresses relative to the window base.
`ifndef VDFW_MAP_VH
`define VDFW_MAP_VH

// Window geometry.
`define VDFW_ADDR_W        8
`define VDFW_DATA_W        32
`define VDFW_NUM_CH        3

// Destination offsets; both luma locations share one offset.
`define VDFW_LUMA_DEST_A   8'h20
`define VDFW_LUMA_DEST_B   8'h20
`define VDFW_BLUE_DEST     8'h28
`define VDFW_RED_DEST      8'h30

// Channel indices.
`define VDFW_CH_LUMA       2'h0
`define VDFW_CH_BLUE       2'h1
`define VDFW_CH_RED        2'h2

// Display modes.
`define VDFW_MODE_BT656    2'h0
`define VDFW_MODE_YC       2'h1
`define VDFW_MODE_RAW      2'h2

// FIFO shape and request pacing.
`define VDFW_FIFO_DEPTH    8
`define VDFW_LEVEL_W       4
`define VDFW_BURST         4'h4
`define VDFW_BURST_LAST    3'h3
// Highest fill level at which a whole burst still fits.
`define VDFW_REQ_LEVEL     4'h4

// Value returned on any read of the window.
`define VDFW_READ_VALUE    32'h0000_0000

`endif

// ---- design/vdfw_fifo.v ----
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps

module vdfw_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3,
    parameter LW    = 4
)(
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    input  wire             flush,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Status
    output wire [LW-1:0]    level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [LW-1:0]    count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != DEPTH[LW-1:0]);
    assign out_valid = (count_reg != {LW{1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr_reg];
    assign level     = count_reg;

    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {LW{1'b0}};
        end
        else if (flush)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {LW{1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + {{(LW-1){1'b0}}, 1'b1};
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - {{(LW-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // vdfw_fifo

// ---- test/vdfw_sva.sv ----
// Checker for the display FIFO write window.
// Assumes it is bound to the window's top module.
`timescale 1ns/1ps
module vdfw_sva (
    // Watched ports
    input logic        clk,
    input logic        rst_n,
    input logic [1:0]  disp_mode,
    input logic        disp_enable,
    input logic        disp_flush,
    input logic        win_sel,
    input logic        win_we,
    input logic [7:0]  win_addr,
    input logic        win_ack,
    input logic [31:0] win_rdata,
    input logic        luma_dma_request,
    input logic        blue_diff_dma_request,
    input logic        red_diff_dma_request,
    input logic        luma_out_ready,
    input logic        blue_out_ready,
    input logic        red_out_ready,
    input logic [3:0]  luma_level,
    input logic [3:0]  blue_level,
    input logic [3:0]  red_level
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wr   = win_sel && win_we && !disp_flush;
    wire hold = !luma_out_ready && !blue_out_ready && !red_out_ready && !disp_flush;
    AST_RAW_QUIET: assert property (disp_mode == 2'h2 && $past(disp_mode) == 2'h2 && $past(disp_mode, 2) == 2'h2
        |-> !blue_diff_dma_request && !red_diff_dma_request) else $error("chroma request in raw mode");
    AST_OFF_QUIET: assert property (!disp_enable && !$past(disp_enable) && !$past(disp_enable, 2)
        |-> !luma_dma_request && !blue_diff_dma_request && !red_diff_dma_request) else $error("request while off");
    AST_ONE_PULSE: assert property (luma_dma_request |=> !luma_dma_request) else $error("request too long");
    AST_DROP_ACK: assert property (wr && !(win_addr inside {8'h20, 8'h28, 8'h30}) |-> win_ack)
        else $error("unmapped write stalled");
    AST_RAW_DROP: assert property (wr && hold && disp_mode == 2'h2 && win_addr != 8'h20
        |-> win_ack ##1 $stable(blue_level) && $stable(red_level)) else $error("chroma write kept in raw mode");
    AST_LUMA_PUSH: assert property (wr && win_ack && disp_enable && hold && win_addr == 8'h20
        |=> luma_level == $past(luma_level) + 4'h1) else $error("luma write not stored");
    AST_BLUE_PUSH: assert property (wr && win_ack && disp_enable && hold && win_addr == 8'h28 && disp_mode != 2'h2
        |=> blue_level == $past(blue_level) + 4'h1) else $error("blue write not stored");
    AST_READ_ACK: assert property (win_sel && !win_we && !win_ack |=> win_ack && win_rdata == 32'h0)
        else $error("read not answered");
    AST_READ_KEEP: assert property (win_sel && !win_we && hold
        |=> $stable(luma_level) && $stable(blue_level) && $stable(red_level)) else $error("read changed a level");
endmodule // vdfw_sva
bind vdfw_write_port vdfw_sva u_sva (.clk, .rst_n, .disp_mode, .disp_enable, .disp_flush, .win_sel, .win_we,
    .win_addr, .win_ack, .win_rdata, .luma_dma_request, .blue_diff_dma_request, .red_diff_dma_request,
    .luma_out_ready, .blue_out_ready, .red_out_ready, .luma_level, .blue_level, .red_level);

// ---- test/vdfw_dma_model.sv ----
// DMA agent model: answers each request event with a burst of four writes.
// Assumes requests are one-cycle pulses and that ack may stall a write.
`timescale 1ns/1ps
module vdfw_dma_model (
    // Window side
    input  wire         clk,
    input  wire [2:0]   req,
    input  wire         slow,
    input  wire         ack,
    output logic        sel,
    output logic [7:0]  addr,
    output logic [31:0] data,
    output wire         busy
);
    int n_req [3];
    int n_done [3];
    int w;
    assign busy = sel || n_req[0] != n_done[0] || n_req[1] != n_done[1] || n_req[2] != n_done[2];
    always @(posedge clk)
    begin
        for (int c = 0; c < 3; c++)
            if (req[c]) n_req[c] <= n_req[c] + 1;
    end
    initial
    begin
        sel = 0;
        addr = 8'h00;
        data = 32'h5a5a0f0f;
        forever
        begin
            @(posedge clk);
            for (int c = 0; c < 3; c++)
                if (n_req[c] != n_done[c])
                begin
                    for (int k = 0; k < 4; k++)
                    begin
                        #1 sel = 1;
                        addr = 8'(8'h20 + 8 * c);
                        data = data * 32'h0019660d + 32'h3c6ef35f;
                        w = 0;
                        do begin @(negedge clk); w++; end while (!ack && w < 200);
                        @(posedge clk);
                        if (slow)
                        begin
                            #1 sel = 0;
                            data = ~data;
                            @(posedge clk);
                        end
                    end
                    #1 sel = 0;
                    data = ~data;
                    n_done[c]++;
                end
        end
    end
endmodule // vdfw_dma_model

// ---- test/vdfw_write_port_tb.sv ----
// Testbench for the display FIFO write window with a DMA agent model.
// Assumes the agent is idle whenever the bench uses the window itself.
`timescale 1ns/1ps
`include "vdfw_map.vh"
module vdfw_write_port_tb;
    logic        clk = 0;
    logic        rst_n = 0;
    logic [1:0]  disp_mode = 2'h0;
    logic        disp_enable = 0;
    logic        disp_flush = 0;
    logic        t_sel = 0;
    logic        t_we = 0;
    logic [7:0]  t_addr = 8'h00;
    logic [31:0] t_data = 32'h0;
    logic        slow = 0;
    logic        drain = 0;
    logic [2:0]  rdy = 3'h0;
    logic [31:0] lfsr = 32'hc3a3319b;
    int          err_total = 0;
    int          n_tests = 0;
    logic [31:0] q [3][$];
    wire         m_sel, busy, win_ack, discard_seen;
    wire [7:0]   m_addr;
    wire [31:0]  m_data, win_rdata;
    wire [2:0]   req, ov;
    wire [31:0]  od [3];
    wire [3:0]   lvl [3];
    wire         win_sel = m_sel | t_sel;
    wire         win_we = m_sel | t_we;
    wire [7:0]   win_addr = m_sel ? m_addr : t_addr;
    wire [31:0]  win_wdata = m_sel ? m_data : t_data;
    vdfw_write_port uut (.clk, .rst_n, .disp_mode, .disp_enable, .disp_flush, .win_sel, .win_we, .win_addr,
        .win_wdata, .win_ack, .win_rdata, .luma_dma_request(req[0]), .blue_diff_dma_request(req[1]),
        .red_diff_dma_request(req[2]), .luma_out_valid(ov[0]), .luma_out_ready(rdy[0]), .luma_out_data(od[0]),
        .blue_out_valid(ov[1]), .blue_out_ready(rdy[1]), .blue_out_data(od[1]), .red_out_valid(ov[2]),
        .red_out_ready(rdy[2]), .red_out_data(od[2]), .luma_level(lvl[0]), .blue_level(lvl[1]),
        .red_level(lvl[2]), .discard_seen);
    vdfw_dma_model u_dma (.clk, .req, .slow, .ack(win_ack), .sel(m_sel), .addr(m_addr), .data(m_data), .busy);
    always #50 clk = ~clk;
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(posedge clk)
    begin
        #1 lfsr = lfsr_step(lfsr);
        rdy = drain ? lfsr[2:0] : 3'h0;
        slow = lfsr[5];
    end
    // Notes every word the window takes into an active FIFO.
    always @(posedge clk)
        if (win_sel && win_we && win_ack && disp_enable && !disp_flush)
            for (int c = 0; c < 3; c++)
                if (win_addr == 8'(8'h20 + 8 * c) && (c == 0 || disp_mode != `VDFW_MODE_RAW))
                    q[c].push_back(win_wdata);
    always @(posedge clk)
        for (int c = 0; c < 3; c++)
            if (ov[c] && rdy[c]) chk(od[c], q[c].pop_front(), "fifo word");
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wt(input int k);
        int w;
        for (w = 0; w < 3000; w++)
        begin
            @(posedge clk);
            #2 if (k == 0 ? !busy && lvl[0] == 8 && (disp_mode == 2 || lvl[1] == 8 && lvl[2] == 8)
                          : lvl[0] == 0 && lvl[1] == 0 && lvl[2] == 0) break;
        end
        if (w == 3000) begin err_total++; end_sim; end
    endtask
    task automatic acc(input logic we, input logic [7:0] a);
        int w;
        @(posedge clk);
        #1 t_sel = 1;
        t_we = we;
        t_addr = a;
        t_data = lfsr;
        w = 0;
        do begin @(negedge clk); w++; end while (!win_ack && w < 20);
        if (!win_ack) begin err_total++; end_sim; end
        if (!we) chk(win_rdata, `VDFW_READ_VALUE, "read data");
        @(posedge clk);
        #1 t_sel = 0;
    endtask
    task automatic lv(input int m);
        for (int c = 0; c < 3; c++) chk(lvl[c], (c == 0 || m != 2) ? 8 : 0, "level");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            #1 disp_mode = m[1:0];
            disp_flush = 1;
            @(posedge clk);
            #1 disp_flush = 0;
            disp_enable = 1;
            chk(discard_seen, 0, "discard flag");
            wt(0);
            lv(m);
            disp_enable = 0;
            for (int a = 0; a < 3; a++) acc(0, 8'(8'h20 + 8 * a));
            lv(m);
            acc(1, 8'h24);
            chk(discard_seen, 1, "discard flag");
            if (m == 2)
            begin
                disp_enable = 1;
                acc(1, 8'h28);
                acc(1, 8'h30);
                disp_enable = 0;
                lv(m);
            end
            drain = 1;
            wt(1);
            drain = 0;
            for (int c = 0; c < 3; c++) chk(q[c].size(), 0, "words left");
            $display("mode %0d done", m);
        end
        end_sim;
    end
endmodule // vdfw_write_port_tb
